// file: hw/startup_ctl_regs.vh
// Register map, field positions and reset values of the startup control registers.
`ifndef STARTUP_CTL_REGS_VH
`define STARTUP_CTL_REGS_VH
// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define ADDR_BUS_TARGET_ADDRESS 8'h0A
`define ADDR_IMAGE_REVISION 8'h0B
`define ADDR_DEVICE_CONTROL 8'h0C
// ------------------------------------------------------------
// Field positions of device_control
// ------------------------------------------------------------
`define BIT_SOFT_RESET_LOW 7
`define BIT_SOFT_SYNC_LOW 6
`define BIT_STARTUP_SYNC 4
`define BIT_SYNC_MUTE 3
`define BIT_KEEP_ALWAYS_ON 2
`define BIT_PARALLEL_CAL 1
`define BIT_AUTO_LOCK_START 0
// ------------------------------------------------------------
// Reset values and control write mask
// ------------------------------------------------------------
`define RST_DEVICE_CONTROL 8'hD9
`define RST_IMAGE_REVISION 8'h00
`define RST_BUS_TARGET_ADDR 7'h54
`define CTL_WRITABLE_MASK 8'hDF
`endif

// file: hw/device_startup_control_regs.v
// Startup control registers: bus target address, image revision and device control.
`timescale 1ns/1ps
// Operation
// - Read-only 7-bit target address in bits 7:1
// - Revision reloads after reset and memory commit
// - Soft reset low returns core to power-up
// - Soft reset never re-runs configuration loading
// - Soft sync low acts as sync pin
// - Startup sync enable syncs after lock
// - Sync mute silences outputs during sync
// - Select always-on or oscillator system clock
// - Parallel mode calibrates both PLLs independently
// - Serial mode calibrates second after first
// - Auto start locks after any reset
// - Without auto start wait for host
`include "startup_ctl_regs.vh"
module device_startup_control_regs (
    // Clock, enable and reset
    input wire ref_clk,
    input wire clk_en,
    input wire rstn,
    input wire hw_reset_pin_n,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    // Non-volatile memory values
    input wire [6:0] nvm_target_addr,
    input wire [7:0] nvm_revision,
    input wire nvm_load_done,
    input wire nvm_commit_done,
    // Sync pin and PLL status
    input wire sync_input_pin,
    input wire sync_done,
    input wire pll1_locked,
    input wire pll1_powered_down,
    input wire pll2_locked,
    input wire pll2_powered_down,
    // Core controls
    output wire core_reset,
    output reg sync_active_ff,
    output wire outputs_mute,
    output reg outputs_enable_ff,
    output wire sysclk_select_osc,
    output wire pll1_cal_start,
    output wire pll2_cal_start,
    output reg lock_seq_active_ff
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] ctl_ff;
    reg [6:0] target_addr_ff;
    reg [7:0] revision_ff;
    reg nvm_loaded_ff;
    reg pin_reset_n_ff;
    reg sync_req_prev_ff;
    reg auto_sync_done_ff;
    reg pll1_cal_ff;
    reg pll2_cal_ff;

    // Decoded conditions
    wire soft_rst;
    wire sync_req;
    wire locked;
    wire ctl_wr;
    wire [7:0] nxt_ctl;
    wire auto_sync_go;

    // Index match used by the device control write decode only.
    function reg_hit;
        input [7:0] addr;
        input [7:0] idx;
        begin
            reg_hit = (addr == idx);
        end
    endfunction

    assign ctl_wr = reg_wr && reg_hit(reg_addr, `ADDR_DEVICE_CONTROL);
    assign nxt_ctl = (reg_wdata & `CTL_WRITABLE_MASK);

    // ------------------------------------------------------------
    // Bus register update
    // ------------------------------------------------------------
    // Bus registers and configuration loader sit outside the core reset, so a soft reset
    // leaves them untouched and the stored image is not transferred again.
    // A commit only refreshes the revision; the target address stays as first loaded.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            ctl_ff <= `RST_DEVICE_CONTROL;
            target_addr_ff <= `RST_BUS_TARGET_ADDR;
            revision_ff <= `RST_IMAGE_REVISION;
            nvm_loaded_ff <= 1'b0;
        end else if (clk_en) begin
            if (ctl_wr) begin
                ctl_ff <= nxt_ctl;
            end
            if (nvm_load_done && !nvm_loaded_ff) begin
                target_addr_ff <= nvm_target_addr;
                revision_ff <= nvm_revision;
                nvm_loaded_ff <= 1'b1;
            end else if (nvm_commit_done) begin
                revision_ff <= nvm_revision;
            end
        end
    end
    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    // Read data is registered and holds until the next read, so the host may sample late.
    // Unmapped indices read as zero rather than aliasing a real register.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata_ff <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                `ADDR_BUS_TARGET_ADDRESS: reg_rdata_ff <= {target_addr_ff, 1'b0};
                `ADDR_IMAGE_REVISION: reg_rdata_ff <= revision_ff;
                `ADDR_DEVICE_CONTROL: reg_rdata_ff <= ctl_ff;
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Core reset and clock select
    // ------------------------------------------------------------
    // The bit stays low until the host writes it back; the core is held meanwhile.
    assign soft_rst = !ctl_ff[`BIT_SOFT_RESET_LOW];
    // The loader is outside this reset, so a soft reset never repeats the image transfer.
    assign core_reset = soft_rst || !pin_reset_n_ff || !nvm_loaded_ff;
    assign locked = pll1_locked && pll2_locked;
    assign sysclk_select_osc = !ctl_ff[`BIT_KEEP_ALWAYS_ON] && locked && !core_reset;
    assign pll1_cal_start = pll1_cal_ff;
    assign pll2_cal_start = pll2_cal_ff;

    // ------------------------------------------------------------
    // Reset pin register
    // ------------------------------------------------------------
    // The pin is taken as synchronous to the clock.
    // One register keeps a pin glitch inside a single cycle of core reset.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pin_reset_n_ff <= 1'b0;
        end else if (clk_en) begin
            pin_reset_n_ff <= hw_reset_pin_n;
        end
    end

    // ------------------------------------------------------------
    // Lock sequence and calibration order
    // ------------------------------------------------------------
    // In serial mode the second loop waits for the first, trading start time for supply load.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            lock_seq_active_ff <= 1'b0;
            outputs_enable_ff <= 1'b0;
            pll1_cal_ff <= 1'b0;
            pll2_cal_ff <= 1'b0;
        end else if (clk_en) begin
            if (core_reset) begin
                lock_seq_active_ff <= 1'b0;
                outputs_enable_ff <= 1'b0;
                pll1_cal_ff <= 1'b0;
                pll2_cal_ff <= 1'b0;
            end else begin
                if (ctl_ff[`BIT_AUTO_LOCK_START]) begin
                    lock_seq_active_ff <= 1'b1;
                end
                if (lock_seq_active_ff) begin
                    pll1_cal_ff <= 1'b1;
                    if (ctl_ff[`BIT_PARALLEL_CAL]) begin
                        pll2_cal_ff <= !pll2_powered_down;
                    end else if (pll1_locked || pll1_powered_down) begin
                        pll2_cal_ff <= !pll2_powered_down;
                    end else begin
                        pll2_cal_ff <= 1'b0;
                    end
                    // Outputs follow the lock state, so they drop again if a loop loses lock.
                    outputs_enable_ff <= locked;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Synchronisation events
    // ------------------------------------------------------------
    assign sync_req = !ctl_ff[`BIT_SOFT_SYNC_LOW] || sync_input_pin;
    assign outputs_mute = sync_active_ff && ctl_ff[`BIT_SYNC_MUTE];
    // The automatic sync runs once per core reset, after both loops have locked.
    assign auto_sync_go = ctl_ff[`BIT_STARTUP_SYNC] && locked && lock_seq_active_ff
                          && !auto_sync_done_ff;
    // A start request wins over sync_done in the same cycle, so no start is lost.
    always @(posedge ref_clk) begin
        if (!rstn) begin
            sync_active_ff <= 1'b0;
            sync_req_prev_ff <= 1'b0;
            auto_sync_done_ff <= 1'b0;
        end else if (clk_en) begin
            if (core_reset) begin
                sync_active_ff <= 1'b0;
                sync_req_prev_ff <= 1'b0;
                auto_sync_done_ff <= 1'b0;
            end else begin
                sync_req_prev_ff <= sync_req;
                if (sync_req && !sync_req_prev_ff) begin
                    sync_active_ff <= 1'b1;
                end else if (auto_sync_go) begin
                    sync_active_ff <= 1'b1;
                    auto_sync_done_ff <= 1'b1;
                end else if (sync_done) begin
                    sync_active_ff <= 1'b0;
                end
            end
        end
    end

endmodule // device_startup_control_regs

// file: verif/pll_lock_model.sv
// Behavioural PLL that locks a fixed time after calibration is allowed.
`timescale 1ns/1ps
module pll_lock_model #(parameter int DLY = 6) (
    input wire logic ref_clk,
    input wire logic cal_start,
    output logic locked
);
    int cnt_ff = 0;
    // Lock drops at once when calibration is withdrawn, like a loop that restarts.
    always @(posedge ref_clk) begin
        cnt_ff <= cal_start ? cnt_ff + 1 : 0;
        locked <= cal_start && cnt_ff >= DLY;
    end
endmodule // pll_lock_model

// file: verif/ctl_chk.sv
// Assertions on the ports of the startup control block.
`timescale 1ns/1ps
module ctl_chk (
    input wire ref_clk, rstn, reg_wr, reg_rd, hw_reset_pin_n, sync_input_pin, core_reset,
    input wire clk_en, sync_active_ff, outputs_mute, pll1_cal_start, lock_seq_active_ff,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence soft_rst_wr;
        clk_en && reg_wr && reg_addr == 8'h0C && !reg_wdata[7];
    endsequence
    addr_bit0_a: assert property (clk_en && reg_rd && reg_addr == 8'h0A |=> !reg_rdata_ff[0])
        else $error("address bit 0 set");
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved");
    soft_reset_a: assert property (soft_rst_wr |=> core_reset)
        else $error("soft reset ignored");
    pin_reset_a: assert property (clk_en && !hw_reset_pin_n |=> core_reset)
        else $error("pin reset ignored");
    pin_sync_a: assert property (clk_en && !core_reset && $rose(sync_input_pin)
        |-> ##[1:3] sync_active_ff)
        else $error("pin sync missed");
    mute_sync_a: assert property (outputs_mute |-> sync_active_ff)
        else $error("mute outside sync");
    seq_gate_a: assert property (clk_en && core_reset |=> !lock_seq_active_ff)
        else $error("lock run in reset");
    cal_after_a: assert property ($rose(pll1_cal_start) |-> $past(lock_seq_active_ff))
        else $error("calibration early");
endmodule // ctl_chk
bind device_startup_control_regs ctl_chk ctl_chk_inst (.*);

// file: verif/tb_top.sv
// Self-checking bench for the startup control registers.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0, rstn = 0, pn = 1, wr = 0, rd = 0, ld = 0, cm = 0, sd = 0, sp = 0, ce = 1;
    logic [7:0] ad = 0, wd = 0, rdat, rev = 8'h3C;
    logic p1, p2, cr, sa, mu, so, c1, c2, ls, oe;
    int err_total = 0, n_compared = 0;
    typedef struct {logic [7:0] a, d, e;} row_t;
    row_t rows[5] = '{'{8'h0A, 8'hFF, 8'hA8}, '{8'h0B, 8'hFF, 8'h3C}, '{8'h0C, 8'hFF, 8'hDF},
        '{8'h0D, 8'h55, 8'h00}, '{8'h0C, 8'hD9, 8'hD9}};
    initial forever #10 ref_clk = ~ref_clk;
    device_startup_control_regs device_startup_control_regs_inst (.ref_clk, .clk_en(ce),
        .rstn, .hw_reset_pin_n(pn), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
        .reg_rdata_ff(rdat), .nvm_target_addr(7'h54), .nvm_revision(rev), .nvm_load_done(ld),
        .nvm_commit_done(cm), .sync_input_pin(sp), .sync_done(sd), .pll1_locked(p1),
        .pll1_powered_down(1'b0), .pll2_locked(p2), .pll2_powered_down(1'b0),
        .core_reset(cr), .sync_active_ff(sa), .outputs_mute(mu), .outputs_enable_ff(oe),
        .sysclk_select_osc(so), .pll1_cal_start(c1), .pll2_cal_start(c2),
        .lock_seq_active_ff(ls));
    pll_lock_model pll_lock_model_inst (.ref_clk, .cal_start(c1), .locked(p1));
    pll_lock_model pll_lock_model_inst_b (.ref_clk, .cal_start(c2), .locked(p2));
    task w(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task chk(string n, logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Requests are held for one taken edge, then dropped for one idle edge.
    task acc(logic [7:0] a, d, bit we);
        ad = a; wd = d; wr = we; rd = !we; w(1); wr = 0; rd = 0; w(1);
    endtask
    task sdp;
        sd = 1; w(1); sd = 0;
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100us; err_total++; results;
    end
    initial begin
        w(8); rstn = 1; ld = 1; w(5);
        chk("cal2", 0, c2);
        chk("lock", 1, ls);
        w(25);
        chk("osc", 1, so);
        chk("sync", 1, sa);
        chk("mute", 1, mu);
        chk("oe", 1, oe);
        sdp; acc(8'h0C, 0, 0);
        chk("ctl", 8'hD9, rdat);
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].d, 1); acc(rows[i].a, 0, 0);
            chk("reg", rows[i].e, rdat);
        end
        $display("registers done");
        rev = 8'h77; acc(8'h0C, 8'h58, 1);
        chk("rst", 1, cr);
        acc(8'h0B, 0, 0);
        chk("rev", 8'h3C, rdat);
        cm = 1; w(1); cm = 0; acc(8'h0B, 0, 0);
        chk("rev", 8'h77, rdat);
        acc(8'h0C, 8'hD8, 1); w(9);
        chk("lock", 0, ls);
        acc(8'h0C, 8'hD9, 1); w(30);
        chk("lock", 1, ls);
        sdp; acc(8'h0C, 8'h91, 1); w(2);
        chk("sync", 1, sa);
        chk("mute", 0, mu);
        acc(8'h0C, 8'h5F, 1); acc(8'h0C, 8'hDF, 1); w(4);
        chk("cal2", 1, c2);
        w(25);
        chk("osc", 0, so);
        pn = 0; w(2);
        chk("rst", 1, cr);
        pn = 1; w(5);
        chk("lock", 1, ls);
        w(40); sdp;
        chk("sync", 0, sa);
        sp = 1; w(2);
        chk("sync", 1, sa);
        chk("mute", 1, mu);
        sp = 0; ce = 0; acc(8'h0C, 8'hD8, 1); ce = 1; acc(8'h0C, 0, 0);
        chk("ctl", 8'hDF, rdat);
        $display("sequencing done");
        results;
    end
endmodule // tb_top
